/* File: pkg/warn_pkg.sv */
// package for the warning source mask and saturation detect block
// assumes a single 125 MHz clock domain and an avalon-mm register slave
package warn_pkg;
   // ==========================================================
   // register word offsets (printed offsets are not word aligned)
   localparam logic [7:0] idx_latched_mask = 8'h1F;
   localparam logic [7:0] idx_live_mask = 8'h20;
   localparam logic [7:0] idx_sat_config = 8'h21;
   localparam logic [7:0] idx_status = 8'h30;
   // reset values
   localparam logic [7:0] rst_latched_mask = 8'h04;
   localparam logic [7:0] rst_live_mask = 8'h00;
   localparam logic [7:0] rst_sat_config = 8'h00;
   // latched mask field positions
   localparam int lat_clip = 6;
   localparam int lat_inv_clock = 5;
   localparam int lat_shutdown = 4;
   localparam int lat_power = 3;
   localparam int lat_overtemp = 2;
   localparam int lat_foldback = 1;
   localparam int lat_current = 0;
   // live mask field positions
   localparam int live_inv_clock = 5;
   localparam int live_shutdown = 4;
   localparam int live_power = 3;
   localparam int live_overtemp = 2;
   localparam int live_foldback = 1;
   localparam int live_unfinished = 0;
   // saturation config field positions
   localparam int sat_enable = 6;
   localparam int sat_level_lo = 4;
   localparam int pair_b_to_group_two = 3;
   localparam int pair_b_to_group_one = 2;
   localparam int pair_a_to_group_two = 1;
   localparam int pair_a_to_group_one = 0;

   // ==========================================================
   // latched flag set
   typedef struct packed {
      logic [3:0] clip;
      logic inv_clock;
      logic [3:0] overtemp_shutdown_flag;
      logic shutdown_global;
      logic battery_undervoltage;
      logic battery_overvoltage;
      logic stage_supply_undervoltage;
      logic stage_supply_overvoltage;
      logic digital_supply_power_on_reset;
      logic gate_drive_supply_fault;
      logic [3:0] overtemp_warning_flag;
      logic overtemp_global;
      logic thermal_foldback_warning;
      logic [3:0] current_limit_source;
   } latched_flags_type;

   // live flag set
   typedef struct packed {
      logic inv_clock;
      logic [3:0] overtemp_shutdown_flag;
      logic shutdown_global;
      logic battery_undervoltage;
      logic battery_overvoltage;
      logic stage_supply_undervoltage;
      logic stage_supply_overvoltage;
      logic gate_drive_supply_fault;
      logic [3:0] overtemp_warning_flag;
      logic overtemp_global;
      logic thermal_foldback_warning;
      logic [3:0] load_diagnostics;
   } live_flags_type;

   // saturation detector outputs toward the pins
   typedef struct packed {
      logic enable;
      logic [1:0] saturation_threshold_level;
      logic group_two;
      logic group_one;
   } clip_out_type;
endpackage : warn_pkg

/* File: design/warn_source_merge.sv */
// warning source merge: ors every enabled latched and live source
// assumes flags are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module warn_source_merge (
   // masks
   input wire logic [7:0] latched_mask,
   input wire logic [7:0] live_mask,
   // sources
   input wire warn_pkg::latched_flags_type lat,
   input wire warn_pkg::live_flags_type live,
   // result
   output logic warn_any
);
   // ==========================================================
   // combine sources
   always_comb begin
      warn_any = 1'b0;
      // latched sources; the reserved bit 7 is never looked at
      if (latched_mask[warn_pkg::lat_clip] && |lat.clip) begin
         warn_any = 1'b1; // see R1
      end
      if (latched_mask[warn_pkg::lat_inv_clock] && lat.inv_clock) begin
         warn_any = 1'b1; // see R2
      end
      if (latched_mask[warn_pkg::lat_shutdown] &&
          (|lat.overtemp_shutdown_flag || lat.shutdown_global)) begin
         warn_any = 1'b1; // see R3
      end
      if (latched_mask[warn_pkg::lat_power] &&
          (lat.battery_undervoltage || lat.battery_overvoltage ||
           lat.stage_supply_undervoltage || lat.stage_supply_overvoltage ||
           lat.digital_supply_power_on_reset ||
           lat.gate_drive_supply_fault)) begin
         warn_any = 1'b1; // see R4
      end
      if (latched_mask[warn_pkg::lat_overtemp] &&
          (|lat.overtemp_warning_flag || lat.overtemp_global)) begin
         warn_any = 1'b1; // see R5
      end
      if (latched_mask[warn_pkg::lat_foldback] &&
          lat.thermal_foldback_warning) begin
         warn_any = 1'b1; // see R6
      end
      if (latched_mask[warn_pkg::lat_current] &&
          |lat.current_limit_source) begin
         warn_any = 1'b1; // see R7
      end
      // live sources; bits 7:6 are reserved
      if (live_mask[warn_pkg::live_inv_clock] && live.inv_clock) begin
         warn_any = 1'b1; // see R9
      end
      if (live_mask[warn_pkg::live_shutdown] &&
          (|live.overtemp_shutdown_flag || live.shutdown_global)) begin
         warn_any = 1'b1; // see R10
      end
      if (live_mask[warn_pkg::live_power] &&
          (live.battery_undervoltage || live.battery_overvoltage ||
           live.stage_supply_undervoltage ||
           live.stage_supply_overvoltage ||
           live.gate_drive_supply_fault)) begin
         warn_any = 1'b1; // see R11
      end
      // live warning flags taken, the ambiguous stored naming is ignored
      if (live_mask[warn_pkg::live_overtemp] &&
          (|live.overtemp_warning_flag || live.overtemp_global)) begin
         warn_any = 1'b1; // see R12
      end
      if (live_mask[warn_pkg::live_foldback] &&
          live.thermal_foldback_warning) begin
         warn_any = 1'b1; // see R13
      end
      if (live_mask[warn_pkg::live_unfinished] &&
          !(&live.load_diagnostics)) begin
         warn_any = 1'b1; // see R14
      end
   end
endmodule : warn_source_merge
`default_nettype wire

/* File: design/clip_group_route.sv */
// clip group routing: maps two channel pairs onto two detect groups
// assumes per-channel clip levels synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module clip_group_route (
   // configuration
   input wire logic [7:0] sat_config,
   // channel clip levels, bit 0 is channel one
   input wire logic [3:0] clip_live,
   // groups
   output logic group_one,
   output logic group_two
);
   logic pair_a; // channel one or two clipping
   logic pair_b; // channel three or four clipping
   logic en; // detector enable
   // ==========================================================
   // routing
   always_comb begin
      en = sat_config[warn_pkg::sat_enable]; // see R17
      pair_a = en && (clip_live[0] || clip_live[1]);
      pair_b = en && (clip_live[2] || clip_live[3]);
      // see R18 see R19
      group_one = (pair_a && sat_config[warn_pkg::pair_a_to_group_one]) ||
                  (pair_b && sat_config[warn_pkg::pair_b_to_group_one]);
      group_two = (pair_a && sat_config[warn_pkg::pair_a_to_group_two]) ||
                  (pair_b && sat_config[warn_pkg::pair_b_to_group_two]);
   end
endmodule : clip_group_route
`default_nettype wire

/* File: design/warning_signal_source_mask.sv */
// warning signal source mask: three registers over avalon-mm that
// steer the warning output and the two clip detect groups
// assumes one clock, synchronous active-low reset, flags synchronous
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// R1: latched clip enable passes any stored clip
// R2: latched invalid clock enable passes stored flag
// R3: latched shutdown enable passes channel or global
// R4: latched power enable passes six supply flags
// R5: latched overtemp warning enable, resets to one
// R6: latched foldback enable passes stored foldback warning
// R7: latched current enable passes any channel limit
// R8: latched mask resets to 04 hex
// R9: live invalid clock enable passes live flag
// R10: live shutdown enable passes channel or global
// R11: live power enable passes five supply flags
// R12: live overtemp enable passes live warnings
// R13: live foldback enable passes live foldback
// R14: unfinished diagnostics enable flags missing reports
// R15: live mask resets to zero
// R16: saturation config resets to zero, fixed layout
// R17: clip detection only while enable set
// R18: routing bits map pairs onto groups
// R19: pair a reaches group via its bit
// R20: warning is or of enabled sources
// R21: reserved bits store and read, no effect
module warning_signal_source_mask (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // avalon-mm slave, word addressed
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   output logic [31:0] readdata,
   output logic waitrequest,
   output logic [1:0] response,
   // diagnostic sources
   input wire warn_pkg::latched_flags_type latched_flags,
   input wire warn_pkg::live_flags_type live_flags,
   input wire logic [3:0] clip_live,
   // outputs
   output logic warning_active,
   output warn_pkg::clip_out_type clip_out
);
   // ==========================================================
   // state
   logic [7:0] latched_mask; // latched source enables
   logic [7:0] live_mask; // live source enables
   logic [7:0] sat_config; // saturation detect setup
   logic [7:0] next_latched_mask;
   logic [7:0] next_live_mask;
   logic [7:0] next_sat_config;
   logic next_ack; // answer cycle comes next
   logic [31:0] next_readdata;
   logic [1:0] next_response;
   logic next_warning;
   warn_pkg::clip_out_type next_clip_out;
   logic warn_any; // merged source level
   logic group_one;
   logic group_two;

   // bus state machine: idle, then one answer cycle
   typedef enum logic [0:0] {
      st_idle = 1'b0,
      st_answer = 1'b1
   } bus_state_type;
   bus_state_type state;
   bus_state_type next_state;

   // ==========================================================
   // address decode
   function automatic logic mapped(input logic [7:0] a);
      mapped = (a == warn_pkg::idx_latched_mask) ||
               (a == warn_pkg::idx_live_mask) ||
               (a == warn_pkg::idx_sat_config) ||
               (a == warn_pkg::idx_status);
   endfunction : mapped

   // ==========================================================
   // sources
   warn_source_merge merge (
      .latched_mask(latched_mask),
      .live_mask(live_mask),
      .lat(latched_flags),
      .live(live_flags),
      .warn_any(warn_any)
   );

   clip_group_route route (
      .sat_config(sat_config),
      .clip_live(clip_live),
      .group_one(group_one),
      .group_two(group_two)
   );

   // ==========================================================
   // next-state logic for registers and bus
   always_comb begin
      next_latched_mask = latched_mask;
      next_live_mask = live_mask;
      next_sat_config = sat_config;
      next_readdata = readdata;
      next_response = response;
      next_state = state;
      next_ack = 1'b0;
      case (state)
         st_idle: begin
            // a request is taken here; the answer comes next cycle
            if (read || write) begin
               next_state = st_answer;
               next_ack = 1'b1;
               next_response = mapped(address) ? 2'h0 : 2'h2;
               next_readdata = 32'h0;
               if (write) begin
                  // whole byte stored, reserved bits too; see R21
                  case (address)
                     warn_pkg::idx_latched_mask: begin
                        next_latched_mask = writedata[7:0];
                     end
                     warn_pkg::idx_live_mask: begin
                        next_live_mask = writedata[7:0];
                     end
                     warn_pkg::idx_sat_config: begin
                        next_sat_config = writedata[7:0]; // see R16
                     end
                     default: begin
                        // status and unmapped words ignore writes
                     end
                  endcase
               end else begin
                  case (address)
                     warn_pkg::idx_latched_mask: begin
                        next_readdata = {24'h0, latched_mask};
                     end
                     warn_pkg::idx_live_mask: begin
                        next_readdata = {24'h0, live_mask};
                     end
                     warn_pkg::idx_sat_config: begin
                        next_readdata = {24'h0, sat_config};
                     end
                     warn_pkg::idx_status: begin
                        // registered warning output and the route groups before their register
                        next_readdata = {29'h0, group_two, group_one,
                                         warning_active};
                     end
                     default: begin
                        next_readdata = 32'h0;
                     end
                  endcase
               end
            end
         end
         st_answer: begin
            // master releases after seeing waitrequest low
            next_state = st_idle;
         end
         default: begin
            next_state = st_idle;
         end
      endcase
   end

   // ==========================================================
   // output next values; one cycle of register delay on each path
   always_comb begin
      next_warning = warn_any; // see R20
      next_clip_out.enable = sat_config[warn_pkg::sat_enable]; // see R17
      next_clip_out.saturation_threshold_level =
         sat_config[warn_pkg::sat_level_lo +: 2];
      next_clip_out.group_one = group_one; // see R18
      next_clip_out.group_two = group_two; // see R19
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         latched_mask <= warn_pkg::rst_latched_mask; // see R8 see R5
         live_mask <= warn_pkg::rst_live_mask; // see R15
         sat_config <= warn_pkg::rst_sat_config; // see R16
         state <= st_idle;
         readdata <= 32'h0;
         response <= 2'h0;
         warning_active <= 1'b0;
         clip_out <= '0;
      end else begin
         latched_mask <= next_latched_mask;
         live_mask <= next_live_mask;
         sat_config <= next_sat_config;
         state <= next_state;
         readdata <= next_readdata;
         response <= next_response;
         warning_active <= next_warning;
         clip_out <= next_clip_out;
      end
   end

   // ==========================================================
   // waitrequest is high except in the answer cycle; registered
   always_ff @(posedge clk) begin
      if (!nrst) begin
         waitrequest <= 1'b1;
      end else begin
         waitrequest <= !next_ack;
      end
   end
endmodule : warning_signal_source_mask
`default_nettype wire

/* File: tb/warn_props.sv */
// checker for the warning source mask block
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module warn_props (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // register bus
   input wire logic [7:0] address,
   input wire logic read,
   input wire logic write,
   input wire logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response,
   // sources and outputs
   input wire warn_pkg::latched_flags_type latched_flags,
   input wire warn_pkg::live_flags_type live_flags,
   input wire logic [3:0] clip_live,
   input wire logic warning_active,
   input wire warn_pkg::clip_out_type clip_out
);
   // ==========================================================
   // shadow masks: they move at the answer edge, one edge after the
   // design, so the checks that use them are skipped while a write completes
   logic [7:0] lm, vm, sm;
   logic [7:0] next_lm, next_vm, next_sm;
   logic sw, exp_warn, g1, g2;
   logic [6:0] ls;
   logic [5:0] vs;
   assign sw = write && !waitrequest;
   // next shadow values
   always_comb begin
      next_lm = !nrst ? 8'h04 : (sw && address == 8'h1F) ? writedata[7:0] : lm;
      next_vm = !nrst ? 8'h00 : (sw && address == 8'h20) ? writedata[7:0] : vm;
      next_sm = !nrst ? 8'h00 : (sw && address == 8'h21) ? writedata[7:0] : sm;
   end
   // shadow registers
   always_ff @(posedge clk) begin
      lm <= next_lm;
      vm <= next_vm;
      sm <= next_sm;
   end
   // source summaries lined up with the mask bits
   assign ls = {|latched_flags[25:22], latched_flags[21], |latched_flags[20:16],
      |latched_flags[15:10], |latched_flags[9:5], latched_flags[4],
      |latched_flags[3:0]};
   assign vs = {live_flags[20], |live_flags[19:15], |live_flags[14:10],
      |live_flags[9:5], live_flags[4], ~&live_flags[3:0]};
   assign exp_warn = |(ls & lm[6:0]) || |(vs & vm[5:0]);
   assign g1 = sm[6] && (sm[0] && |clip_live[1:0] || sm[2] && |clip_live[3:2]);
   assign g2 = sm[6] && (sm[1] && |clip_live[1:0] || sm[3] && |clip_live[3:2]);

   // ==========================================================
   // properties
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   sequence s_take;
      (read || write) && waitrequest;
   endsequence
   sequence s_answer;
      !waitrequest ##1 waitrequest;
   endsequence
   AST_ANSWER: assert property (s_take |=> s_answer)
      else $error("bus answer not one cycle after request");
   AST_UNMAPPED: assert property ((read || write) && !waitrequest
      && !(address inside {8'h1F, 8'h20, 8'h21, 8'h30}) |-> response == 2'b10)
      else $error("unmapped index not refused");
   AST_READBACK: assert property (read && !waitrequest && address == 8'h1F
      |-> readdata == {24'h0, lm}) else $error("latched mask readback wrong");
   AST_WARN_OR: assert property (!sw |=> warning_active == $past(exp_warn))
      else $error("warning differs from or of enabled sources");
   AST_CLIP_LATCH: assert property (!sw && lm[6] && |latched_flags[25:22]
      |=> warning_active) else $error("stored clip did not warn");
   AST_INCOMPLETE: assert property (!sw && vm[0] && !(&live_flags[3:0])
      |=> warning_active) else $error("missing report did not warn");
   AST_GROUP_ONE: assert property (!sw |=> clip_out.group_one == $past(g1))
      else $error("group one wrong");
   AST_GROUP_TWO: assert property (!sw |=> clip_out.group_two == $past(g2))
      else $error("group two wrong");
   AST_SAT_OFF: assert property (!sw && !sm[6] |=> !clip_out.group_one
      && !clip_out.group_two) else $error("group active while disabled");
   AST_SAT_FIELDS: assert property (!sw |=> clip_out.enable == $past(sm[6])
      && clip_out.saturation_threshold_level == $past(sm[5:4]))
      else $error("saturation fields wrong");
endmodule : warn_props

bind warning_signal_source_mask warn_props props (.clk(clk), .nrst(nrst),
   .address(address), .read(read), .write(write), .writedata(writedata),
   .readdata(readdata), .waitrequest(waitrequest), .response(response),
   .latched_flags(latched_flags), .live_flags(live_flags),
   .clip_live(clip_live), .warning_active(warning_active), .clip_out(clip_out));
`default_nettype wire

/* File: tb/host_model.sv */
// host controller model: an avalon-mm master that sets the masks
// assumes the slave answers by dropping waitrequest
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic clk,
   // avalon-mm master side
   output logic [7:0] address,
   output logic read,
   output logic write,
   output logic [31:0] writedata,
   input wire logic [31:0] readdata,
   input wire logic waitrequest,
   input wire logic [1:0] response
);
   // ==========================================================
   // idle bus from time zero
   initial begin
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
   end
   // one transfer; held until waitrequest is sampled low, then released,
   // so a following call lets one edge pass before raising again
   task automatic xfer(input logic wr, input logic [7:0] a, input logic [7:0] d,
         output logic [31:0] rd, output logic [1:0] rsp);
      @(posedge clk);
      address <= a;
      read <= !wr;
      write <= wr;
      writedata <= {24'h0, d};
      @(posedge clk);
      // no cycle count of its own: only the bench's hang guard ends a wait
      while (waitrequest !== 1'b0) begin
         @(posedge clk);
      end
      rd = readdata;
      rsp = response;
      read <= 1'b0;
      write <= 1'b0;
   endtask : xfer
endmodule : host_model
`default_nettype wire

/* File: tb/tb_top.sv */
// testbench for the warning source mask block
// assumes the host model as bus master and flags driven from here
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   // ==========================================================
   // signals
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic [7:0] address;
   logic read, write, warn;
   logic [31:0] writedata, readdata, rd, r;
   logic waitrequest;
   logic [1:0] response, rsp;
   warn_pkg::latched_flags_type lf = '0;
   warn_pkg::live_flags_type vf = '1;
   logic [3:0] cl = 4'h0;
   warn_pkg::clip_out_type co;
   logic [7:0] m [3] = '{8'h04, 8'h00, 8'h00};
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 32'h22B9;
   int cyc = 0;

   // 125 MHz clock
   always #4 clk = ~clk;
   host_model host (.clk(clk), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .response(response));
   warning_signal_source_mask dut (.clk(clk), .nrst(nrst), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .response(response), .latched_flags(lf),
      .live_flags(vf), .clip_live(cl), .warning_active(warn), .clip_out(co));

   // ==========================================================
   // compares, model and verdict
   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: value %h, expected %h", $time, got, exp);
      end
   endtask : chk_val
   task automatic chk_bit(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: output %b, expected %b", $time, got, exp);
      end
   endtask : chk_bit
   task automatic stop_test;
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : stop_test
   // reference model: {group_two, group_one, warning}
   function automatic logic [2:0] model();
      logic [6:0] ls;
      logic [5:0] vs;
      ls = {|lf[25:22], lf[21], |lf[20:16], |lf[15:10], |lf[9:5], lf[4], |lf[3:0]};
      vs = {vf[20], |vf[19:15], |vf[14:10], |vf[9:5], vf[4], ~&vf[3:0]};
      model[0] = |(ls & m[0][6:0]) || |(vs & m[1][5:0]);
      model[1] = m[2][6] && (m[2][0] && |cl[1:0] || m[2][2] && |cl[3:2]);
      model[2] = m[2][6] && (m[2][1] && |cl[1:0] || m[2][3] && |cl[3:2]);
   endfunction : model
   // read all three masks back
   task automatic chk_regs;
      for (int a = 0; a < 3; a++) begin
         host.xfer(1'b0, 8'h1F + 8'(a), 8'h00, rd, rsp);
         chk_val(rd, {24'h0, m[a]});
      end
   endtask : chk_regs
   // outputs follow inputs one clock late; look after two edges
   task automatic settle_check;
      logic [2:0] e;
      repeat (2) @(posedge clk);
      #1;
      e = model();
      chk_bit(warn, e[0]);
      chk_bit(co.group_one, e[1]);
      chk_bit(co.group_two, e[2]);
      chk_val({30'h0, co.saturation_threshold_level}, {30'h0, m[2][5:4]});
   endtask : settle_check

   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         stop_test();
      end
   end

   // ==========================================================
   // main sequence
   initial begin
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      chk_regs();
      host.xfer(1'b0, 8'h40, 8'h00, rd, rsp);
      chk_val({30'h0, rsp}, 32'h2);
      // single latched enables first, then single live enables beside random latched masks, then random masks with reserved bits
      for (int i = 0; i < 40; i++) begin
         m[0] = (i < 7) ? 8'h01 << i : 8'($random(seed));
         m[1] = (i >= 7 && i < 13) ? 8'h01 << (i - 7) : 8'h00;
         if (i >= 13) begin
            m[1] = 8'($random(seed));
         end
         m[2] = 8'($random(seed));
         for (int a = 0; a < 3; a++) begin
            host.xfer(1'b1, 8'h1F + 8'(a), m[a], rd, rsp);
         end
         chk_regs();
         repeat (6) begin
            @(posedge clk);
            r = $random(seed) & $random(seed) & $random(seed);
            lf <= r[25:0];
            vf <= {r[20:4], ~r[3:0]};
            cl <= 4'($random(seed));
            settle_check();
         end
         // status word holds the registered warning and the route groups before their register, flags held steady
         host.xfer(1'b0, 8'h30, 8'h00, rd, rsp);
         chk_val(rd, {29'h0, model()});
         chk_val({30'h0, rsp}, 32'h0);
      end
      // reset in mid-run brings the masks back
      @(posedge clk);
      nrst <= 1'b0;
      repeat (2) @(posedge clk);
      nrst <= 1'b1;
      m = '{8'h04, 8'h00, 8'h00};
      chk_regs();
      @(posedge clk);
      // of the stored flags only the global overtemp warning (bit 5) raised; every live flag high, live mask zero
      lf <= 26'h0000020;
      vf <= '1;
      settle_check();
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
